// ===== sssc_top.sv
// Supply switch and sleep controller: registers, switches, sleep timer
// Assumes comparator flags already synchronous to i_clk; serial port
// delivers byte writes as one-cycle strobes and defaults come from NVM
`timescale 1ns/10ps
`default_nettype none
`include "sssc_consts.svh"
// Functional notes
// - Main off: ground if tie-low bit, else float
// - Force-LDO turns LDO on above upper level
// - Weak mode opens grounds whose disable bit set
// - Weak mode turns off flagged aux outputs
// - Weak mode turns off main when flagged
// - Aux setting: STS, LDO, auto float, auto ground
// - Disconnected aux grounded only for setting three
// - Auto ground opens outside battery-application range
// - Force-off bit stops boost converter pumping
// - Aux enables connect only above upper level
// - Sleep enable disconnects main for sleep time
// - Primary cell mode never charges long-term storage
// - Link on weak flag or two low samples
// - Auto link held two harvester periods
// - Below lower level storages stay disconnected
// - Force link only in primary cell mode
// - Protection status blocks forced link
// - Sleep touches only the main output and the serial port
// - Wake event ends sleep early
// - Serial port disabled during sleep
// - Wake debouncer bypassed when enable cleared
// - Edge field selects fall, rise or both
// - Sleep time is 24-bit millisecond count
module sssc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port and NVM defaults
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_nvm_load,
  input wire logic [79:0] i_nvm_data,
  output logic [7:0] o_reg_rdata,
  output logic o_serial_en,
  // Comparator and status flags
  input wire logic i_sts_above_upper,
  input wire logic i_sts_below_trip,
  input wire logic i_sts_in_range,
  input wire logic i_sts_above_apl_max,
  input wire logic i_lts_below_lower,
  input wire logic i_hrv_low,
  input wire logic i_hrv_meas_done,
  input wire logic i_lts_protect,
  input wire logic i_sts_meas,
  // Wake pin
  input wire logic i_wake_pin,
  // Switch controls
  output logic [1:0] o_main_src,
  output logic [5:0] o_aux_src,
  output logic [2:0] o_aux_gnd_close,
  output logic o_ldo_on,
  output logic o_dcdc_off,
  output logic o_lts_charge_en,
  output logic o_storage_link,
  output logic o_sleeping
);
  localparam int TICK_CYC = `SSSC_TICK_CYC;
  localparam logic [1:0] SRC_OFF = 2'(sssc_pkg::SSSC_OFF);
  localparam logic [1:0] SRC_STS = 2'(sssc_pkg::SSSC_STS);
  localparam logic [1:0] SRC_LDO = 2'(sssc_pkg::SSSC_LDO);
  localparam logic [1:0] SRC_GND = 2'(sssc_pkg::SSSC_GND);

  logic [7:0] storage_q, main_ldo_q, weak_q, aux_cfg_q, aux_gnd_q;
  logic [7:0] wake_q, slp_lo_q, slp_mid_q, slp_hi_q, pwr_q;
  logic [23:0] sleep_cnt_q;
  logic [16:0] tick_cnt_q;
  logic tick;
  sssc_pkg::sssc_sleep_t sleep_st_q;
  logic wake_evt;
  logic reg_wr_ok;
  logic link_auto_q;
  logic [1:0] hold_q;
  logic low_seen_q;
  logic [1:0] main_src_d;
  logic [5:0] aux_src_d;
  logic [2:0] gnd_close_d;
  logic link_d;
  logic [7:0] rdata_d;

  // Registers stop taking writes while the main supply sleeps
  assign reg_wr_ok = i_reg_wr && (sleep_st_q == sssc_pkg::SSSC_AWAKE);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      storage_q <= 8'h00;
      main_ldo_q <= 8'h00;
      weak_q <= 8'h00;
      aux_cfg_q <= 8'h00;
      aux_gnd_q <= 8'h00;
      wake_q <= 8'h50;
      slp_lo_q <= 8'h00;
      slp_mid_q <= 8'h00;
      slp_hi_q <= 8'h00;
      pwr_q <= 8'h00;
    end else if (i_nvm_load) begin
      storage_q <= i_nvm_data[7:0] & 8'h07;
      main_ldo_q <= i_nvm_data[15:8];
      weak_q <= i_nvm_data[23:16];
      aux_cfg_q <= i_nvm_data[31:24] & 8'h3f;
      aux_gnd_q <= i_nvm_data[39:32] & 8'h07;
      wake_q <= i_nvm_data[47:40];
      slp_lo_q <= i_nvm_data[55:48];
      slp_mid_q <= i_nvm_data[63:56];
      slp_hi_q <= i_nvm_data[71:64];
      pwr_q <= i_nvm_data[79:72];
    end else if (reg_wr_ok) begin
      case (i_reg_addr)
        `SSSC_OFS_STORAGE_MODE: storage_q <= i_reg_wdata & 8'h07;
        `SSSC_OFS_MAIN_LDO: main_ldo_q <= i_reg_wdata;
        `SSSC_OFS_WEAK_SW: weak_q <= i_reg_wdata;
        `SSSC_OFS_AUX_OUT: aux_cfg_q <= i_reg_wdata & 8'h3f;
        `SSSC_OFS_AUX_GND: aux_gnd_q <= i_reg_wdata & 8'h07;
        `SSSC_OFS_WAKE_PAD: wake_q <= i_reg_wdata;
        `SSSC_OFS_SLEEP_LO: slp_lo_q <= i_reg_wdata;
        `SSSC_OFS_SLEEP_MID: slp_mid_q <= i_reg_wdata;
        `SSSC_OFS_SLEEP_HI: slp_hi_q <= i_reg_wdata;
        `SSSC_OFS_PWR_EN: pwr_q <= i_reg_wdata;
        default: ;
      endcase
    end else if (sleep_st_q == sssc_pkg::SSSC_SLEEP &&
                 (wake_evt || (tick && sleep_cnt_q <= 24'h1))) begin
      // Sleep bit drops when the state ends
      pwr_q[`SSSC_BIT_SLEEP_EN] <= 1'b0;
    end
  end

  always_comb begin
    case (i_reg_addr)
      `SSSC_OFS_STORAGE_MODE: rdata_d = storage_q;
      `SSSC_OFS_MAIN_LDO: rdata_d = main_ldo_q;
      `SSSC_OFS_WEAK_SW: rdata_d = weak_q;
      `SSSC_OFS_AUX_OUT: rdata_d = aux_cfg_q;
      `SSSC_OFS_AUX_GND: rdata_d = aux_gnd_q;
      `SSSC_OFS_WAKE_PAD: rdata_d = wake_q;
      `SSSC_OFS_SLEEP_LO: rdata_d = slp_lo_q;
      `SSSC_OFS_SLEEP_MID: rdata_d = slp_mid_q;
      `SSSC_OFS_SLEEP_HI: rdata_d = slp_hi_q;
      `SSSC_OFS_PWR_EN: rdata_d = pwr_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
      o_serial_en <= 1'b1;
    end else begin
      o_reg_rdata <= rdata_d;
      o_serial_en <= (sleep_st_q == sssc_pkg::SSSC_AWAKE);
    end
  end

  // Millisecond tick
  always_ff @(posedge i_clk) begin
    if (i_srst || tick) begin
      tick_cnt_q <= 17'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h1;
    end
  end
  assign tick = (tick_cnt_q == 17'(TICK_CYC - 1));

  sssc_wake_filter i_sssc_wake_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_deb_en(wake_q[`SSSC_BIT_DEB_EN]),
    .i_edge_sel(wake_q[`SSSC_BIT_EDGE_LO +: 2]),
    .i_pin(i_wake_pin),
    .o_event(wake_evt)
  );

  // Sleep state and countdown
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sleep_st_q <= sssc_pkg::SSSC_AWAKE;
      sleep_cnt_q <= 24'h0;
    end else begin
      case (sleep_st_q)
        sssc_pkg::SSSC_AWAKE: begin
          if (pwr_q[`SSSC_BIT_SLEEP_EN]) begin
            sleep_st_q <= sssc_pkg::SSSC_SLEEP;
            sleep_cnt_q <= {slp_hi_q, slp_mid_q, slp_lo_q};
          end
        end
        sssc_pkg::SSSC_SLEEP: begin
          if (wake_evt) begin
            sleep_st_q <= sssc_pkg::SSSC_AWAKE;
            sleep_cnt_q <= 24'h0;
          end else if (tick) begin
            if (sleep_cnt_q <= 24'h1) begin
              sleep_st_q <= sssc_pkg::SSSC_AWAKE;
              sleep_cnt_q <= 24'h0;
            end else begin
              sleep_cnt_q <= sleep_cnt_q - 24'h1;
            end
          end
        end
        default: sleep_st_q <= sssc_pkg::SSSC_AWAKE;
      endcase
    end
  end

  // Primary-cell automatic link with two-period hold
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      low_seen_q <= 1'b0;
      link_auto_q <= 1'b0;
      hold_q <= 2'h0;
    end else if (!storage_q[`SSSC_BIT_PRIM_CELL] || i_lts_below_lower) begin
      low_seen_q <= 1'b0;
      link_auto_q <= 1'b0;
      hold_q <= 2'h0;
    end else begin
      if (i_sts_meas) begin
        low_seen_q <= i_sts_below_trip;
      end
      if (i_hrv_low || (i_sts_meas && i_sts_below_trip && low_seen_q)) begin
        link_auto_q <= 1'b1;
        hold_q <= 2'h2;
      end else if (i_hrv_meas_done && hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (hold_q == 2'h0) begin
        link_auto_q <= 1'b0;
      end
    end
  end

  assign link_d = ~i_lts_below_lower & storage_q[`SSSC_BIT_PRIM_CELL] &
                  (link_auto_q | (storage_q[`SSSC_BIT_FORCE_LINK] &
                   ~i_lts_protect));

  // Main supply source
  always_comb begin
    if (sleep_st_q == sssc_pkg::SSSC_SLEEP ||
        (i_hrv_low && weak_q[`SSSC_BIT_WEAK_MAIN_OFF])) begin
      main_src_d = main_ldo_q[`SSSC_BIT_GND_WHEN_OFF] ? SRC_GND : SRC_OFF;
    end else if (main_ldo_q[`SSSC_BIT_FORCE_LDO] && i_sts_above_upper) begin
      main_src_d = SRC_LDO;
    end else if (i_sts_above_apl_max) begin
      main_src_d = SRC_LDO;
    end else if (i_sts_in_range) begin
      main_src_d = SRC_STS;
    end else begin
      main_src_d = main_ldo_q[`SSSC_BIT_GND_WHEN_OFF] ? SRC_GND : SRC_OFF;
    end
  end

  // Auxiliary outputs and grounds; not affected by sleep
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_aux
      logic [1:0] cfg;
      logic on;
      logic gon;
      assign cfg = aux_cfg_q[2*g +: 2];
      assign on = pwr_q[`SSSC_BIT_AUX_EN_LO + g] & i_sts_above_upper &
                  ~(i_hrv_low & weak_q[`SSSC_BIT_WEAK_AUX_LO + g]);
      always_comb begin
        if (!on) begin
          aux_src_d[2*g +: 2] = (cfg == `SSSC_CFG_AUTO_GND) ? SRC_GND
                                                          : SRC_OFF;
        end else begin
          case (cfg)
            `SSSC_CFG_STS: aux_src_d[2*g +: 2] = SRC_STS;
            `SSSC_CFG_LDO: aux_src_d[2*g +: 2] = SRC_LDO;
            `SSSC_CFG_AUTO_FLOAT: aux_src_d[2*g +: 2] =
              i_sts_above_apl_max ? SRC_LDO :
              (i_sts_in_range ? SRC_STS : SRC_OFF);
            default: aux_src_d[2*g +: 2] =
              i_sts_above_apl_max ? SRC_LDO :
              (i_sts_in_range ? SRC_STS : SRC_GND);
          endcase
        end
      end
      assign gon = pwr_q[`SSSC_BIT_GND_EN_LO + g] & i_sts_above_upper;
      assign gnd_close_d[g] = gon &
        ~(aux_gnd_q[g] & ~i_sts_in_range) &
        ~(i_hrv_low & weak_q[`SSSC_BIT_WEAK_GND_LO + g]);
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_main_src <= SRC_OFF;
      o_aux_src <= {3{SRC_OFF}};
      o_aux_gnd_close <= 3'h0;
      o_ldo_on <= 1'b0;
      o_dcdc_off <= 1'b0;
      o_lts_charge_en <= 1'b0;
      o_storage_link <= 1'b0;
      o_sleeping <= 1'b0;
    end else begin
      o_main_src <= main_src_d;
      o_aux_src <= aux_src_d;
      o_aux_gnd_close <= gnd_close_d;
      o_ldo_on <= (main_ldo_q[`SSSC_BIT_FORCE_LDO] & i_sts_above_upper) |
                  i_sts_above_apl_max;
      o_dcdc_off <= pwr_q[`SSSC_BIT_DCDC_OFF];
      o_lts_charge_en <= ~storage_q[`SSSC_BIT_PRIM_CELL] &
                         ~pwr_q[`SSSC_BIT_DCDC_OFF];
      o_storage_link <= link_d;
      o_sleeping <= (sleep_st_q == sssc_pkg::SSSC_SLEEP);
    end
  end

  chk_sleep_floats_main: assert property (@(posedge i_clk) disable iff (i_srst)
    o_sleeping |-> (o_main_src == SRC_OFF || o_main_src == SRC_GND))
    else $error("main supply live during sleep");
  chk_tie_low_ground: assert property (@(posedge i_clk) disable iff (i_srst)
    (sleep_st_q == sssc_pkg::SSSC_SLEEP && main_ldo_q[7]) |=>
    o_main_src == SRC_GND)
    else $error("main not grounded when off");
  chk_serial_off: assert property (@(posedge i_clk) disable iff (i_srst)
    o_sleeping |-> !o_serial_en)
    else $error("serial port live in sleep");
  chk_wake_ends: assert property (@(posedge i_clk) disable iff (i_srst)
    (sleep_st_q == sssc_pkg::SSSC_SLEEP && wake_evt) |=> ##1 !o_sleeping)
    else $error("wake did not end sleep");
  chk_dcdc_force: assert property (@(posedge i_clk) disable iff (i_srst)
    pwr_q[7] |=> o_dcdc_off)
    else $error("dcdc still pumping");
  chk_prim_no_charge: assert property (@(posedge i_clk) disable iff (i_srst)
    storage_q[1] |=> !o_lts_charge_en)
    else $error("long-term storage charged in primary mode");
  chk_link_lower: assert property (@(posedge i_clk) disable iff (i_srst)
    i_lts_below_lower |=> !o_storage_link)
    else $error("link while battery too low");
  chk_link_protect: assert property (@(posedge i_clk) disable iff (i_srst)
    (!link_auto_q && i_lts_protect) |=> !o_storage_link)
    else $error("forced link under protection");
  chk_aux_upper: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_sts_above_upper |=> (o_aux_gnd_close == 3'h0))
    else $error("ground closed below upper level");
  chk_count_down: assert property (@(posedge i_clk) disable iff (i_srst)
    (sleep_st_q == sssc_pkg::SSSC_SLEEP && tick && !wake_evt &&
     sleep_cnt_q > 24'h1) |=> sleep_cnt_q == $past(sleep_cnt_q) - 24'h1)
    else $error("sleep counter did not step");
  cov_sleep: cover property (@(posedge i_clk) o_sleeping ##1 !o_sleeping);
  cov_wake: cover property (@(posedge i_clk) wake_evt && o_sleeping);
  cov_link: cover property (@(posedge i_clk) o_storage_link && link_auto_q);
endmodule
`default_nettype wire

// ===== sssc_consts.svh
// Register offsets, field positions, field codes and timing counts
// Assumes a 125 MHz core clock
`ifndef SSSC_CONSTS_SVH
`define SSSC_CONSTS_SVH
`define SSSC_OFS_STORAGE_MODE 8'h06
`define SSSC_OFS_MAIN_LDO 8'h0e
`define SSSC_OFS_WEAK_SW 8'h0f
`define SSSC_OFS_AUX_OUT 8'h10
`define SSSC_OFS_AUX_GND 8'h11
`define SSSC_OFS_WAKE_PAD 8'h13
`define SSSC_OFS_SLEEP_LO 8'h14
`define SSSC_OFS_SLEEP_MID 8'h15
`define SSSC_OFS_SLEEP_HI 8'h16
`define SSSC_OFS_PWR_EN 8'h19
`define SSSC_BIT_GND_WHEN_OFF 7
`define SSSC_BIT_FORCE_LDO 3
`define SSSC_BIT_WEAK_MAIN_OFF 0
`define SSSC_BIT_WEAK_AUX_LO 1
`define SSSC_BIT_WEAK_GND_LO 4
`define SSSC_BIT_DCDC_OFF 7
`define SSSC_BIT_GND_EN_LO 4
`define SSSC_BIT_AUX_EN_LO 1
`define SSSC_BIT_SLEEP_EN 0
`define SSSC_BIT_PRIM_CELL 1
`define SSSC_BIT_FORCE_LINK 2
`define SSSC_BIT_DEB_EN 6
`define SSSC_BIT_EDGE_LO 4
`define SSSC_EDGE_FALL 2'h1
`define SSSC_EDGE_RISE 2'h2
`define SSSC_EDGE_BOTH 2'h3
`define SSSC_CFG_STS 2'h0
`define SSSC_CFG_LDO 2'h1
`define SSSC_CFG_AUTO_FLOAT 2'h2
`define SSSC_CFG_AUTO_GND 2'h3
`define SSSC_CLK_MHZ 125
`define SSSC_TICK_US 1000
`define SSSC_TICK_CYC (`SSSC_TICK_US * `SSSC_CLK_MHZ)
`define SSSC_DEB_US 100
`define SSSC_DEB_CYC (`SSSC_DEB_US * `SSSC_CLK_MHZ)
`endif

// ===== sssc_pkg.sv
// Types shared by the supply switch controller
// Assumes nothing beyond the constants header
package sssc_pkg;
  typedef enum logic [1:0] {SSSC_AWAKE, SSSC_SLEEP} sssc_sleep_t;
  typedef enum logic [1:0] {SSSC_OFF, SSSC_STS, SSSC_LDO, SSSC_GND} sssc_src_t;
endpackage

// ===== sssc_wake_filter.sv
// Wake pin synchroniser, debouncer and edge detector
// Assumes an asynchronous pin and the core clock
`timescale 1ns/10ps
`default_nettype none
`include "sssc_consts.svh"
module sssc_wake_filter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Configuration
  input wire logic i_deb_en,
  input wire logic [1:0] i_edge_sel,
  // Pin and event
  input wire logic i_pin,
  output logic o_event
);
  localparam int DEB_CYC = `SSSC_DEB_CYC;
  logic s1_q, s2_q, stable_q, prev_q;
  logic [13:0] cnt_q;
  logic filt;

  always_ff @(posedge i_clk) begin
    // Pin idles high: reset matches it, so no false edge follows reset
    if (i_srst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
    end
  end

  // Level must hold for the debounce time before it is accepted
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stable_q <= 1'b1;
      cnt_q <= 14'h0;
    end else if (s2_q == stable_q) begin
      cnt_q <= 14'h0;
    end else if (cnt_q == 14'(DEB_CYC - 1)) begin
      stable_q <= s2_q;
      cnt_q <= 14'h0;
    end else begin
      cnt_q <= cnt_q + 14'h1;
    end
  end

  assign filt = i_deb_en ? stable_q : s2_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_q <= 1'b1;
      o_event <= 1'b0;
    end else begin
      prev_q <= filt;
      o_event <= (i_edge_sel[0] & prev_q & ~filt) |
                 (i_edge_sel[1] & ~prev_q & filt);
    end
  end
endmodule
`default_nettype wire

// ===== sssc_app_model.sv
// Application controller model fed from the main supply output
// Assumes it shares the core clock and owns the wake push button
`timescale 1ns/10ps
`default_nettype none
module sssc_app_model (
  // Clock and supply
  input wire logic i_clk,
  input wire logic [1:0] i_main_src,
  // Button level asked for by the bench
  input wire logic i_wake_level,
  // Pin and status
  output var logic o_wake_pin,
  output logic o_powered
);
  // Button idles high, so the default falling edge is a press
  initial o_wake_pin = 1'b1;
  // Pin moves on the edge after the request, never mid-cycle
  always @(posedge i_clk) begin
    o_wake_pin <= i_wake_level;
  end
  // Alive only while fed from storage or the regulator
  assign o_powered = (i_main_src == 2'h1) || (i_main_src == 2'h2);
endmodule
`default_nettype wire

// ===== test_sssc_top.sv
// Self-checking bench for the supply switch and sleep controller
// Assumes the design files and the application model compile first
`timescale 1ns/10ps
`default_nettype none
module test_sssc_top;
  logic i_clk, i_srst, i_reg_wr, i_nvm_load, i_wake_pin, wake_level, s;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [79:0] i_nvm_data;
  logic i_sts_above_upper, i_sts_below_trip, i_sts_in_range;
  logic i_sts_above_apl_max, i_lts_below_lower, i_hrv_low;
  logic i_hrv_meas_done, i_lts_protect, i_sts_meas, powered;
  logic o_serial_en, o_ldo_on, o_dcdc_off, o_lts_charge_en;
  logic o_storage_link, o_sleeping;
  logic [1:0] o_main_src;
  logic [5:0] o_aux_src;
  logic [2:0] o_aux_gnd_close;
  logic [7:0] ofs [10] = '{8'h06, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h13,
    8'h14, 8'h15, 8'h16, 8'h19};
  logic [7:0] nvm [10] = '{8'h07, 8'h8b, 8'h7f, 8'h3f, 8'h07, 8'h70,
    8'h12, 8'h34, 8'h56, 8'h7e};
  int mismatches, samples_checked, cycles;

  sssc_top i_sssc_top (
    .i_clk, .i_srst, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_nvm_load,
    .i_nvm_data, .o_reg_rdata, .o_serial_en, .i_sts_above_upper,
    .i_sts_below_trip, .i_sts_in_range, .i_sts_above_apl_max,
    .i_lts_below_lower, .i_hrv_low, .i_hrv_meas_done, .i_lts_protect,
    .i_sts_meas, .i_wake_pin, .o_main_src, .o_aux_src, .o_aux_gnd_close,
    .o_ldo_on, .o_dcdc_off, .o_lts_charge_en, .o_storage_link, .o_sleeping
  );
  sssc_app_model i_sssc_app_model (
    .i_clk, .i_main_src(o_main_src), .i_wake_level(wake_level),
    .o_wake_pin(i_wake_pin), .o_powered(powered)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, well above the longest debounce wait
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    tick(1);
    chk($sformatf("register %h", a), exp, o_reg_rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic pulse(input bit sts);
    if (sts) i_sts_meas = 1'b1;
    else i_hrv_meas_done = 1'b1;
    tick(1);
    i_sts_meas = 1'b0;
    i_hrv_meas_done = 1'b0;
    tick(1);
  endtask
  task automatic wait_awake(input int n);
    for (int k = 0; k < n && o_sleeping !== 1'b0; k++) tick(1);
  endtask
  function automatic logic [1:0] aux_exp(input logic [1:0] c,
                                         input logic con);
    if (con) return (c == 2'h1) ? 2'h2 : 2'h1;
    return (c == 2'h3) ? 2'h3 : 2'h0;
  endfunction
  function automatic logic [1:0] aux_rng(input logic [1:0] c);
    return c[1] ? {2{c[0]}} : aux_exp(c, 1'b1);
  endfunction
  function automatic logic [7:0] dflt(input int k);
    return (ofs[k] == 8'h13) ? 8'h50 : 8'h00;
  endfunction

  initial begin
    {i_reg_wr, i_nvm_load, i_sts_below_trip, i_sts_above_apl_max} = '0;
    {i_lts_below_lower, i_hrv_low, i_hrv_meas_done, i_lts_protect} = '0;
    {i_sts_meas, i_reg_addr, i_reg_wdata} = '0;
    {i_sts_above_upper, i_sts_in_range, wake_level, i_srst} = '1;
    for (int k = 0; k < 10; k++) i_nvm_data[k*8 +: 8] = nvm[k];
    tick(16);
    chk("serial enable", 8'h1, o_serial_en);
    chk("main source", 8'h0, o_main_src);
    i_srst = 1'b0;
    for (int k = 0; k < 10; k++) chk_reg(ofs[k], dflt(k));
    wr(8'h07, 8'haa);
    chk_reg(8'h07, 8'h00);
    i_nvm_load = 1'b1;
    tick(1);
    i_nvm_load = 1'b0;
    for (int k = 0; k < 10; k++) chk_reg(ofs[k], nvm[k]);
    for (int k = 0; k < 10; k++) wr(ofs[k], dflt(k));
    for (int k = 0; k < 10; k++) chk_reg(ofs[k], dflt(k));
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, {2'h0, c[1:0], c[1:0], c[1:0]});
      wr(8'h19, 8'h0e);
      chk("aux on", {2'h0, {3{aux_exp(c[1:0], 1'b1)}}}, o_aux_src);
      i_sts_in_range = 1'b0;
      tick(2);
      chk("aux range", {2'h0, {3{aux_rng(c[1:0])}}}, o_aux_src);
      i_sts_in_range = 1'b1;
      i_sts_above_upper = 1'b0;
      tick(2);
      chk("aux low", {2'h0, {3{aux_exp(c[1:0], 1'b0)}}}, o_aux_src);
      i_sts_above_upper = 1'b1;
      wr(8'h19, 8'h00);
      chk("aux off", {2'h0, {3{aux_exp(c[1:0], 1'b0)}}}, o_aux_src);
    end
    wr(8'h10, 8'h00);
    wr(8'h19, 8'h7e);
    wr(8'h11, 8'h02);
    wr(8'h0e, 8'h80);
    wr(8'h0f, 8'h1b);
    chk("gnd normal", 8'h07, o_aux_gnd_close);
    chk("main normal", 8'h1, o_main_src);
    i_sts_in_range = 1'b0;
    tick(2);
    chk("gnd auto", 8'h05, o_aux_gnd_close);
    i_sts_in_range = 1'b1;
    i_hrv_low = 1'b1;
    tick(2);
    chk("aux weak", 8'h04, o_aux_src);
    chk("gnd weak", 8'h06, o_aux_gnd_close);
    chk("main weak", 8'h3, o_main_src);
    wr(8'h0e, 8'h00);
    chk("main float", 8'h0, o_main_src);
    i_hrv_low = 1'b0;
    wr(8'h0e, 8'h08);
    chk("ldo forced", 8'h1, o_ldo_on);
    i_sts_above_upper = 1'b0;
    tick(2);
    chk("ldo low", 8'h0, o_ldo_on);
    i_sts_above_upper = 1'b1;
    wr(8'h0e, 8'h00);
    wr(8'h19, 8'h80);
    chk("dcdc off", 8'h1, o_dcdc_off);
    wr(8'h19, 8'h00);
    chk("dcdc auto", 8'h0, o_dcdc_off);
    wr(8'h06, 8'h02);
    chk("lts charge", 8'h0, o_lts_charge_en);
    wr(8'h06, 8'h00);
    chk("lts charge", 8'h1, o_lts_charge_en);
    wr(8'h06, 8'h04);
    chk("link", 8'h0, o_storage_link);
    wr(8'h06, 8'h06);
    chk("link", 8'h1, o_storage_link);
    i_lts_protect = 1'b1;
    tick(2);
    chk("link", 8'h0, o_storage_link);
    i_lts_protect = 1'b0;
    i_lts_below_lower = 1'b1;
    tick(2);
    chk("link", 8'h0, o_storage_link);
    i_lts_below_lower = 1'b0;
    wr(8'h06, 8'h02);
    i_hrv_low = 1'b1;
    tick(2);
    chk("link", 8'h1, o_storage_link);
    i_hrv_low = 1'b0;
    pulse(1'b0);
    tick(2);
    chk("link", 8'h1, o_storage_link);
    pulse(1'b0);
    tick(2);
    chk("link", 8'h0, o_storage_link);
    i_sts_below_trip = 1'b1;
    pulse(1'b1);
    tick(2);
    chk("link", 8'h0, o_storage_link);
    pulse(1'b1);
    tick(2);
    chk("link", 8'h1, o_storage_link);
    i_sts_below_trip = 1'b0;
    wr(8'h06, 8'h00);
    for (int k = 6; k < 9; k++) wr(ofs[k], 8'hff);
    for (int k = 6; k < 9; k++) chk_reg(ofs[k], 8'hff);
    wr(8'h0e, 8'h80);
    wr(8'h19, 8'h03);
    tick(1);
    chk("asleep", 8'h1, o_sleeping);
    chk("main sleep", 8'h3, o_main_src);
    chk("serial", 8'h0, o_serial_en);
    chk("aux sleep", 8'h01, o_aux_src);
    chk("app power", 8'h0, powered);
    wr(8'h14, 8'h55);
    wake_level = 1'b0;
    tick(10000);
    chk("debounce", 8'h1, o_sleeping);
    wait_awake(4000);
    chk("awake", 8'h0, o_sleeping);
    tick(2);
    chk("main back", 8'h1, o_main_src);
    chk("app power", 8'h1, powered);
    chk("serial", 8'h1, o_serial_en);
    chk_reg(8'h14, 8'hff);
    wr(8'h0e, 8'h00);
    for (int m = 1; m < 4; m++) begin
      s = (m == 2);
      wr(8'h13, {2'h0, m[1:0], 4'h0});
      wake_level = s;
      tick(20);
      wr(8'h19, 8'h03);
      tick(1);
      chk("main float", 8'h0, o_main_src);
      wake_level = !s;
      if (m != 3) begin
        tick(20);
        chk("wrong edge", 8'h1, o_sleeping);
        wake_level = s;
      end
      wait_awake(20);
      chk("edge wake", 8'h0, o_sleeping);
      chk_reg(8'h19, 8'h02);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
